// ### design/gsr_pkg.sv
// constants and types of the gas sensor host readout
package gsr_pkg;
  // system clock
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned MS_PER_S = 1000;
  localparam int unsigned S_PER_MIN = 60;
  localparam int unsigned MIN_PER_DAY = 1440;
  // cycles per millisecond, the base of every long timer
  localparam int unsigned MS_CYCLES = CLK_HZ / MS_PER_S;
  // calibration windows in minutes, auto period in days, sample period in seconds
  localparam int unsigned MANUAL_MIN_MIN = 2;
  localparam int unsigned MANUAL_MAX_MIN = 4;
  localparam int unsigned AUTO_CLEAN_MIN = 3;
  localparam int unsigned AUTO_PERIOD_DAYS = 7;
  localparam int unsigned SAMPLE_S = 3;
  localparam int unsigned MANUAL_MIN_MS = MANUAL_MIN_MIN * S_PER_MIN * MS_PER_S;
  localparam int unsigned MANUAL_MAX_MS = MANUAL_MAX_MIN * S_PER_MIN * MS_PER_S;
  localparam int unsigned AUTO_PERIOD_MS = AUTO_PERIOD_DAYS * MIN_PER_DAY * S_PER_MIN * MS_PER_S;
  localparam int unsigned SAMPLE_MS = SAMPLE_S * MS_PER_S;
  localparam int unsigned MS_CNT_W = 30;
  // serial port: 8 data bits, no parity, one stop bit
  localparam int unsigned BAUD_DEFAULT = 38_400;
  localparam int unsigned BAUD_LOW = 9_600;
  localparam int unsigned BAUD_MID = 19_200;
  localparam int unsigned UART_DATA_BITS = 8;
  localparam int unsigned UART_STOP_BITS = 1;
  localparam logic [15:0] BAUD_DIV_DEFAULT = 16'(CLK_HZ / BAUD_DEFAULT);
  localparam logic [15:0] BAUD_DIV_LOW = 16'(CLK_HZ / BAUD_LOW);
  localparam logic [15:0] BAUD_DIV_MID = 16'(CLK_HZ / BAUD_MID);
  localparam logic [1:0] BAUD_SEL_LOW = 2'h1;
  localparam logic [1:0] BAUD_SEL_MID = 2'h2;
  // two-wire addressing
  localparam logic [6:0] SLAVE_ADDR = 7'h31;
  localparam logic [7:0] READ_REQ_CMD = 8'h52;
  localparam logic [2:0] BIT_LAST = 3'h7;
  // record bytes
  localparam int unsigned REC_LEN = 12;
  localparam logic [3:0] REC_LAST = 4'hB;
  localparam logic [3:0] REC_D2 = 4'h3;
  localparam logic [3:0] REC_D1 = 4'h4;
  localparam logic [3:0] REC_PCT = 4'h5;
  localparam logic [3:0] REC_SP2 = 4'h6;
  localparam logic [3:0] REC_P1 = 4'h7;
  localparam logic [3:0] REC_P2 = 4'h8;
  localparam logic [3:0] REC_M = 4'h9;
  localparam logic [3:0] REC_CR = 4'hA;
  localparam logic [7:0] CH_SPACE = 8'h20;
  localparam logic [7:0] CH_ZERO = 8'h30;
  localparam logic [7:0] CH_PCT = 8'h25;
  localparam logic [7:0] CH_P = 8'h70;
  localparam logic [7:0] CH_M = 8'h6D;
  localparam logic [7:0] CH_CR = 8'h0D;
  localparam logic [7:0] CH_LF = 8'h0A;
  // fifo shape
  localparam int unsigned FIFO_W = 8;
  localparam int unsigned FIFO_D = 32;
  // two-wire slave states, one-hot
  typedef enum logic [6:0] {
    LNK_IDLE = 7'h01,
    LNK_ADDR = 7'h02,
    LNK_ADDR_ACK = 7'h04,
    LNK_WR_DATA = 7'h08,
    LNK_WR_ACK = 7'h10,
    LNK_RD_DATA = 7'h20,
    LNK_RD_ACK = 7'h40
  } gsr_link_state_t;
  // concentration digits from the measuring core, bcd
  typedef struct packed {
    logic [3:0] tens;
    logic [3:0] ones;
  } gsr_digits_t;
  // decoded calibration pin state
  typedef struct packed {
    logic manual_cal_mode;
    logic auto_cal_mode;
    logic normal;
    logic pin_fault;
  } gsr_cal_status_t;
endpackage

// ### design/gsr_readout.sv
// record fifo and top of the gas sensor host readout
//
// Contract
// R1 - manual pin low, auto high: manual zero cal
// R2 - manual high, auto low: periodic automatic zero cal
// R3 - both pins high: normal operation, stored cal
// R4 - host never drives both pins low; the bench host does once, to check the fault flag
// R5 - manual cal released between two and four minutes
// R6 - twelve byte record, fixed ascii layout
// R7 - leading zero digit shown as space
// R8 - slave only, address 0x31 plus r/w
// R9 - address byte 0x63 read, 0x62 write
// R10 - host writes 'R' then stops to request
// R11 - host reads seven bytes, acking each one; the bench host nacks the last
// R12 - host waits one millisecond per read byte
// R13 - serial port 38400 8n1, 9600/19200 selectable
// R14 - concentration refreshed every three seconds
// R15 - ignore address bytes not matching own address
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// synchronous fifo with valid/ready on both sides
module gsr_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 32
) (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];  // storage
  logic [AW-1:0] wr_ptr_r;  // next write slot
  logic [AW-1:0] rd_ptr_r;  // next read slot
  logic [AW:0] count_r;  // words held, one bit wider to show full
  logic push;
  logic pop;

  assign in_ready_out = (count_r != (AW+1)'(DEPTH));
  assign out_valid_out = (count_r != '0);
  assign out_data_out = mem_r[rd_ptr_r];
  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;

  // storage write, no reset needed for data
  always_ff @(posedge clk_in) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data_in;
    end
  end

  // pointers and fill level
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
      end
      // both at once leaves the level unchanged
      if (push && !pop) begin
        count_r <= count_r + 1'b1;
      end else if (pop && !push) begin
        count_r <= count_r - 1'b1;
      end
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////////
// top: calibration pins, sampling, record builder, two-wire slave on link clock
module gsr_readout #(
  parameter int unsigned MS_CYC = gsr_pkg::MS_CYCLES,
  parameter int unsigned MAN_MIN_MS = gsr_pkg::MANUAL_MIN_MS,
  parameter int unsigned MAN_MAX_MS = gsr_pkg::MANUAL_MAX_MS,
  parameter int unsigned AUTO_MS = gsr_pkg::AUTO_PERIOD_MS,
  parameter int unsigned SAMPLE_PER_MS = gsr_pkg::SAMPLE_MS,
  parameter int unsigned FIFO_WIDTH = gsr_pkg::FIFO_W,
  parameter int unsigned FIFO_DEPTH = gsr_pkg::FIFO_D
) (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic link_clk_in,
  input wire logic manual_zero_cal_pin_in,
  input wire logic auto_zero_cal_pin_in,
  input wire gsr_pkg::gsr_digits_t concentration_digits_in,
  input wire logic [1:0] baud_sel_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  output gsr_pkg::gsr_cal_status_t cal_status_out,
  output logic manual_zero_calibration_out,
  output logic manual_cal_abort_out,
  output logic periodic_zero_calibration_out,
  output logic [15:0] baud_div_out
);
  import gsr_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // system domain declarations
  logic man_s1_r, man_s2_r;  // manual pin synchroniser
  logic auto_s1_r, auto_s2_r;  // auto pin synchroniser
  logic [$clog2(MS_CYC)-1:0] pre_r;  // millisecond prescaler
  logic ms_tick_r;  // one cycle per millisecond
  logic [MS_CNT_W-1:0] man_ms_r;  // time spent in manual mode
  logic man_prev_r;  // manual mode last cycle
  logic [MS_CNT_W-1:0] auto_ms_r;  // time toward next periodic cal
  logic [MS_CNT_W-1:0] samp_ms_r;  // time toward next sample
  gsr_digits_t digits_r;  // latest sampled concentration
  logic req_s1_r, req_s2_r, req_s3_r;  // read request toggle from link
  logic fet_s1_r, fet_s2_r;  // byte fetch toggle from link
  logic fet_ack_r;  // fetch answer toggle back to link
  logic fet_req_tgl_r;  // fetch request toggle
  logic rd_req_tgl_r;  // read request toggle to the system side
  logic [7:0] xfer_byte_r;  // byte handed to the link, stable while acked
  logic prod_busy_r;  // record being written to the fifo
  logic [3:0] prod_idx_r;  // record byte index
  logic [7:0] rec_byte;  // record byte at prod_idx_r
  logic fifo_in_ready, fifo_out_valid, fifo_out_ready;
  logic [7:0] fifo_out_data;
  logic man_mode, auto_mode;

  assign man_mode = !man_s2_r && auto_s2_r;
  assign auto_mode = man_s2_r && !auto_s2_r;

  // pins come from the host, two flops before use
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      {man_s1_r, man_s2_r, auto_s1_r, auto_s2_r} <= 4'hF;
    end else begin
      man_s1_r <= manual_zero_cal_pin_in;
      man_s2_r <= man_s1_r;
      auto_s1_r <= auto_zero_cal_pin_in;
      auto_s2_r <= auto_s1_r;
    end
  end

  // millisecond base keeps every long counter narrow
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      pre_r <= '0;
      ms_tick_r <= 1'b0;
    end else begin
      ms_tick_r <= (pre_r == ($clog2(MS_CYC))'(MS_CYC - 1));
      pre_r <= (pre_r == ($clog2(MS_CYC))'(MS_CYC - 1)) ? '0 : pre_r + 1'b1;
    end
  end

  // decoded mode, both-low is flagged and treated as normal
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      cal_status_out <= '{manual_cal_mode: 1'b0, auto_cal_mode: 1'b0,
                          normal: 1'b1, pin_fault: 1'b0};
    end else begin
      // R1 manual pin decode
      cal_status_out.manual_cal_mode <= man_mode;
      // R2 auto pin decode
      cal_status_out.auto_cal_mode <= auto_mode;
      // R3 normal keeps stored cal
      cal_status_out.normal <= !man_mode && !auto_mode;
      // R4 illegal both-low flagged
      cal_status_out.pin_fault <= !man_s2_r && !auto_s2_r;
    end
  end

  // manual calibration timing; only a release inside the window stores
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      man_ms_r <= '0;
      man_prev_r <= 1'b0;
      manual_zero_calibration_out <= 1'b0;
      manual_cal_abort_out <= 1'b0;
    end else begin
      man_prev_r <= man_mode;
      manual_zero_calibration_out <= 1'b0;
      manual_cal_abort_out <= 1'b0;
      if (man_mode) begin
        // saturate so a forgotten pin never wraps into the window
        if (ms_tick_r && man_ms_r != '1) begin
          man_ms_r <= man_ms_r + 1'b1;
        end
      end else begin
        man_ms_r <= '0;
      end
      // R5 release window checked
      if (man_prev_r && !man_mode) begin
        if (man_ms_r >= MS_CNT_W'(MAN_MIN_MS) && man_ms_r <= MS_CNT_W'(MAN_MAX_MS)) begin
          manual_zero_calibration_out <= 1'b1;
        end else begin
          manual_cal_abort_out <= 1'b1;
        end
      end
    end
  end

  // periodic calibration pulse once per period while auto mode holds
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      auto_ms_r <= '0;
      periodic_zero_calibration_out <= 1'b0;
    end else begin
      periodic_zero_calibration_out <= 1'b0;
      // R2 weekly automatic zero
      if (!auto_mode) begin
        auto_ms_r <= '0;
      end else if (ms_tick_r) begin
        if (auto_ms_r == MS_CNT_W'(AUTO_MS - 1)) begin
          auto_ms_r <= '0;
          periodic_zero_calibration_out <= 1'b1;
        end else begin
          auto_ms_r <= auto_ms_r + 1'b1;
        end
      end
    end
  end

  // concentration sampling
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      samp_ms_r <= '0;
      digits_r <= '0;
    end else if (ms_tick_r) begin
      // R14 three second refresh
      if (samp_ms_r == MS_CNT_W'(SAMPLE_PER_MS - 1)) begin
        samp_ms_r <= '0;
        digits_r <= concentration_digits_in;
      end else begin
        samp_ms_r <= samp_ms_r + 1'b1;
      end
    end
  end

  // serial rate divisor; unknown selections fall back to the default
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      baud_div_out <= BAUD_DIV_DEFAULT;
    end else begin
      // R13 rate select
      case (baud_sel_in)
        BAUD_SEL_LOW: baud_div_out <= BAUD_DIV_LOW;
        BAUD_SEL_MID: baud_div_out <= BAUD_DIV_MID;
        default: baud_div_out <= BAUD_DIV_DEFAULT;
      endcase
    end
  end

  // record byte by index
  always_comb begin
    // R6 fixed record layout
    unique case (prod_idx_r)
      // R7 leading zero blanked
      REC_D2: rec_byte = (digits_r.tens == 4'h0) ? CH_SPACE : (CH_ZERO | {4'h0, digits_r.tens});
      REC_D1: rec_byte = CH_ZERO | {4'h0, digits_r.ones};
      REC_PCT: rec_byte = CH_PCT;
      REC_P1, REC_P2: rec_byte = CH_P;
      REC_M: rec_byte = CH_M;
      REC_CR: rec_byte = CH_CR;
      REC_LAST: rec_byte = CH_LF;
      default: rec_byte = CH_SPACE;  // leading spaces and the gap
    endcase
  end

  // read request from the link starts one record into the fifo
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      {req_s1_r, req_s2_r, req_s3_r} <= 3'h0;
      prod_busy_r <= 1'b0;
      prod_idx_r <= '0;
    end else begin
      req_s1_r <= rd_req_tgl_r;
      req_s2_r <= req_s1_r;
      req_s3_r <= req_s2_r;
      // R10 'R' request starts record
      if (!prod_busy_r && (req_s2_r != req_s3_r)) begin
        prod_busy_r <= 1'b1;
        prod_idx_r <= '0;
      end else if (prod_busy_r && fifo_in_ready) begin
        // a full fifo stalls the builder here
        prod_busy_r <= (prod_idx_r != REC_LAST);
        prod_idx_r <= prod_idx_r + 1'b1;
      end
    end
  end

  gsr_fifo #(
    .WIDTH(FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .in_valid_in(prod_busy_r),
    .in_ready_out(fifo_in_ready),
    .in_data_in(rec_byte),
    .out_valid_out(fifo_out_valid),
    .out_ready_in(fifo_out_ready),
    .out_data_out(fifo_out_data)
  );

  // a fetch is served only once the fifo holds a byte
  assign fifo_out_ready = (fet_s2_r != fet_ack_r);

  // fetch handshake, system side
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      {fet_s1_r, fet_s2_r} <= 2'h0;
      fet_ack_r <= 1'b0;
      xfer_byte_r <= CH_SPACE;
    end else begin
      fet_s1_r <= fet_req_tgl_r;
      fet_s2_r <= fet_s1_r;
      if (fifo_out_ready && fifo_out_valid) begin
        xfer_byte_r <= fifo_out_data;
        fet_ack_r <= ~fet_ack_r;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // link domain
  logic lrst_s1_r, lrst_r;  // reset carried into the link domain
  logic scl_s1_r, scl_s2_r, scl_s3_r;  // scl synchroniser plus history
  logic sda_s1_r, sda_s2_r, sda_s3_r;  // sda synchroniser plus history
  logic ack_s1_r, ack_s2_r;  // fetch answer synchroniser
  logic fet_pend_r;  // fetch outstanding
  logic [7:0] tx_buf_r;  // next byte ready to send
  logic tx_buf_valid_r;
  logic byte_full_r;  // a whole byte shifted in
  gsr_link_state_t lnk_state_r;
  logic [2:0] bit_cnt_r;
  logic [7:0] shift_r;
  logic is_read_r;
  logic scl_rise, scl_fall, start_cond, stop_cond, load_tx;

  assign scl_rise = scl_s2_r && !scl_s3_r;
  assign scl_fall = !scl_s2_r && scl_s3_r;
  assign start_cond = scl_s2_r && scl_s3_r && !sda_s2_r && sda_s3_r;
  assign stop_cond = scl_s2_r && scl_s3_r && sda_s2_r && !sda_s3_r;
  assign load_tx = scl_fall && ((lnk_state_r == LNK_ADDR_ACK && is_read_r) ||
                                (lnk_state_r == LNK_RD_ACK));

  // reset and pin synchronisers of the link domain
  always_ff @(posedge link_clk_in) begin
    lrst_s1_r <= sys_rst_in;
    lrst_r <= lrst_s1_r;
    scl_s1_r <= scl_in;
    scl_s2_r <= scl_s1_r;
    scl_s3_r <= scl_s2_r;
    sda_s1_r <= sda_in;
    sda_s2_r <= sda_s1_r;
    sda_s3_r <= sda_s2_r;
    ack_s1_r <= fet_ack_r;
    ack_s2_r <= ack_s1_r;
  end

  // keep one byte prefetched so the bit after an ack is ready at once
  always_ff @(posedge link_clk_in) begin
    if (lrst_r) begin
      fet_req_tgl_r <= 1'b0;
      fet_pend_r <= 1'b0;
      tx_buf_r <= CH_SPACE;
      tx_buf_valid_r <= 1'b0;
    end else begin
      if (fet_pend_r && (ack_s2_r == fet_req_tgl_r)) begin
        tx_buf_r <= xfer_byte_r;
        tx_buf_valid_r <= 1'b1;
        fet_pend_r <= 1'b0;
      end else if (!fet_pend_r && !tx_buf_valid_r) begin
        fet_req_tgl_r <= ~fet_req_tgl_r;
        fet_pend_r <= 1'b1;
      end
      if (load_tx) begin
        tx_buf_valid_r <= 1'b0;
      end
    end
  end

  // two-wire slave; never drives scl, sda only pulled low
  always_ff @(posedge link_clk_in) begin
    if (lrst_r) begin
      lnk_state_r <= LNK_IDLE;
      bit_cnt_r <= '0;
      shift_r <= '0;
      is_read_r <= 1'b0;
      rd_req_tgl_r <= 1'b0;
      byte_full_r <= 1'b0;
      sda_out <= 1'b0;
      sda_oe_out <= 1'b0;
    end else if (start_cond) begin
      // a repeated start restarts address reception from any state
      lnk_state_r <= LNK_ADDR;
      bit_cnt_r <= '0;
      byte_full_r <= 1'b0;
      sda_oe_out <= 1'b0;
    end else if (stop_cond) begin
      lnk_state_r <= LNK_IDLE;
      sda_oe_out <= 1'b0;
    end else begin
      unique case (lnk_state_r)
        LNK_IDLE: begin
          sda_oe_out <= 1'b0;
        end
        LNK_ADDR, LNK_WR_DATA: begin
          if (scl_rise) begin
            shift_r <= {shift_r[6:0], sda_s2_r};
            bit_cnt_r <= bit_cnt_r + 1'b1;
            byte_full_r <= (bit_cnt_r == BIT_LAST);
          end else if (scl_fall && byte_full_r && lnk_state_r == LNK_ADDR) begin
            // R8 R15 own address only
            if (shift_r[7:1] == SLAVE_ADDR) begin
              // R9 r/w bit sets direction
              is_read_r <= shift_r[0];
              sda_oe_out <= 1'b1;
              lnk_state_r <= LNK_ADDR_ACK;
            end else begin
              lnk_state_r <= LNK_IDLE;
            end
          end else if (scl_fall && byte_full_r) begin
            // R10 request byte acked
            if (shift_r == READ_REQ_CMD) begin
              rd_req_tgl_r <= ~rd_req_tgl_r;
            end
            sda_oe_out <= 1'b1;
            lnk_state_r <= LNK_WR_ACK;
          end
        end
        LNK_ADDR_ACK: begin
          if (load_tx) begin
            // R11 first read byte
            shift_r <= tx_buf_valid_r ? tx_buf_r : CH_SPACE;
            sda_oe_out <= tx_buf_valid_r ? !tx_buf_r[7] : !CH_SPACE[7];
            bit_cnt_r <= '0;
            lnk_state_r <= LNK_RD_DATA;
          end else if (scl_fall) begin
            sda_oe_out <= 1'b0;
            bit_cnt_r <= '0;
            lnk_state_r <= LNK_WR_DATA;
          end
        end
        LNK_WR_ACK: begin
          if (scl_fall) begin
            sda_oe_out <= 1'b0;
            bit_cnt_r <= '0;
            lnk_state_r <= LNK_WR_DATA;
          end
        end
        LNK_RD_DATA: begin
          if (scl_fall) begin
            if (bit_cnt_r == BIT_LAST) begin
              // release for the host's acknowledge
              sda_oe_out <= 1'b0;
              lnk_state_r <= LNK_RD_ACK;
            end else begin
              shift_r <= {shift_r[6:0], 1'b0};
              sda_oe_out <= !shift_r[6];
              bit_cnt_r <= bit_cnt_r + 1'b1;
            end
          end
        end
        LNK_RD_ACK: begin
          if (scl_rise && sda_s2_r) begin
            // no acknowledge ends the read
            lnk_state_r <= LNK_IDLE;
          end else if (load_tx) begin
            // R11 next byte after ack
            shift_r <= tx_buf_valid_r ? tx_buf_r : CH_SPACE;
            sda_oe_out <= tx_buf_valid_r ? !tx_buf_r[7] : !CH_SPACE[7];
            bit_cnt_r <= '0;
            lnk_state_r <= LNK_RD_DATA;
          end
        end
        default: begin
          lnk_state_r <= LNK_IDLE;
          sda_oe_out <= 1'b0;
        end
      endcase
    end
  end
endmodule

`default_nettype wire

// ### testbench/gsr_host_model.sv
// behavioural two-wire host facing the readout slave
`timescale 1ns/1ps
`default_nettype none
module gsr_host_model #(
  parameter int HALF = 20,
  parameter int MS = 10
) (
  input wire logic clk_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_low_out
);
  // bus idle: clock high, data released to the pull-up
  initial begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end
  task automatic wt();
    repeat (HALF) @(posedge clk_in);
  endtask
  // data moves only while scl is low, sampled at the end of the high phase
  task automatic bit_io(input logic b, output logic r);
    sda_low_out <= !b;
    wt();
    scl_out <= 1'b1;
    wt();
    r = sda_in;
    scl_out <= 1'b0;
  endtask
  task automatic start();
    sda_low_out <= 1'b0;
    wt();
    scl_out <= 1'b1;
    wt();
    sda_low_out <= 1'b1;
    wt();
    scl_out <= 1'b0;
  endtask
  task automatic stop();
    sda_low_out <= 1'b1;
    wt();
    scl_out <= 1'b1;
    wt();
    sda_low_out <= 1'b0;
    wt();
  endtask
  task automatic wr_byte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(b[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask
  // wait a millisecond, ack all but the last byte
  task automatic rd_byte(input logic last, output logic [7:0] b);
    logic r;
    repeat (MS) @(posedge clk_in);
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      b[i] = r;
    end
    // a final nack lets the slave free sda so the stop can be seen
    bit_io(last, r);
  endtask
endmodule
`default_nettype wire

// ### testbench/gsr_readout_sva.sv
// concurrent checks on the readout top ports
`timescale 1ns/1ps
`default_nettype none
module gsr_readout_sva (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic link_clk_in,
  input wire logic manual_zero_cal_pin_in,
  input wire logic auto_zero_cal_pin_in,
  input wire logic [1:0] baud_sel_in,
  input wire logic scl_in,
  input wire logic sda_out,
  input wire logic sda_oe_out,
  input wire gsr_pkg::gsr_cal_status_t cal_status_out,
  input wire logic manual_zero_calibration_out,
  input wire logic periodic_zero_calibration_out,
  input wire logic [15:0] baud_div_out
);
  import gsr_pkg::*;
  // pin levels seen as active-low selects; five samples cover the sync lag
  logic man_lo;
  logic aut_lo;
  assign man_lo = !manual_zero_cal_pin_in;
  assign aut_lo = !auto_zero_cal_pin_in;
  chk_manual_status: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (man_lo && !aut_lo) [*5] |-> cal_status_out == 4'h8) else $error("manual not shown");
  chk_auto_status: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (!man_lo && aut_lo) [*5] |-> cal_status_out == 4'h4) else $error("auto not shown");
  chk_normal_status: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (!man_lo && !aut_lo) [*5] |-> cal_status_out == 4'h2) else $error("normal not shown");
  chk_both_low_fault: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (man_lo && aut_lo) [*5] |-> cal_status_out == 4'h3) else $error("fault not shown");
  chk_no_early_done: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    $rose(cal_status_out.manual_cal_mode) |=> (!manual_zero_calibration_out) [*8])
    else $error("manual done too early");
  chk_periodic_in_auto: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    periodic_zero_calibration_out |-> cal_status_out.auto_cal_mode)
    else $error("periodic pulse outside auto");
  chk_baud_divisor: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !$past(sys_rst_in) && $stable(baud_sel_in) |-> baud_div_out == (baud_sel_in ==
    BAUD_SEL_LOW ? BAUD_DIV_LOW : baud_sel_in == BAUD_SEL_MID ? BAUD_DIV_MID :
    BAUD_DIV_DEFAULT)) else $error("baud divisor wrong");
  chk_open_drain: assert property (@(posedge link_clk_in) disable iff (sys_rst_in)
    !sda_out) else $error("sda data not low");
  // the slave may only move the data line while the host holds scl low
  chk_oe_scl_low: assert property (@(posedge link_clk_in) disable iff (sys_rst_in)
    $changed(sda_oe_out) |-> !scl_in) else $error("sda moved with scl high");
endmodule
bind gsr_readout gsr_readout_sva chk (.*);
`default_nettype wire

// ### testbench/test_gsr_readout.sv
// self-checking bench for the gas sensor readout
`timescale 1ns/1ps
`default_nettype none
module test_gsr_readout;
  import gsr_pkg::*;
  logic clk = 1'b0;
  logic lclk = 1'b0;
  logic rst = 1'b1;
  logic man = 1'b1;
  logic aut = 1'b1;
  gsr_digits_t digits = 8'h42;
  logic [1:0] bsel = 2'h0;
  wire logic scl;
  wire logic hlow;
  logic sda_o;
  logic sda_oe;
  wire logic sda = !(hlow || sda_oe);
  gsr_cal_status_t status;
  logic done;
  logic abort;
  logic per;
  logic [15:0] div;
  int mismatches = 0;
  int comparisons = 0;
  int n_done = 0;
  int n_abort = 0;
  int n_per = 0;
  int cycles = 0;
  int dur[3] = '{60, 20, 120};
  initial forever #10 clk = ~clk;
  // link clock runs free at 12 ns with its own phase
  initial begin
    #3;
    forever #6 lclk = ~lclk;
  end
  gsr_readout #(.MS_CYC(10), .MAN_MIN_MS(4), .MAN_MAX_MS(8), .AUTO_MS(20),
    .SAMPLE_PER_MS(6)) dut (.clk_in(clk), .sys_rst_in(rst), .link_clk_in(lclk),
    .manual_zero_cal_pin_in(man), .auto_zero_cal_pin_in(aut),
    .concentration_digits_in(digits), .baud_sel_in(bsel), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_o), .sda_oe_out(sda_oe), .cal_status_out(status),
    .manual_zero_calibration_out(done), .manual_cal_abort_out(abort),
    .periodic_zero_calibration_out(per), .baud_div_out(div));
  gsr_host_model host (.clk_in(clk), .sda_in(sda), .scl_out(scl),
    .sda_low_out(hlow));
  task complete_run();
    if (mismatches == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s exp %h seen %h", what, exp, seen);
    end
  endtask
  // pulse tally and hang guard
  always @(posedge clk) begin
    n_done <= n_done + (done === 1'b1);
    n_abort <= n_abort + (abort === 1'b1);
    n_per <= n_per + (per === 1'b1);
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      mismatches++;
      complete_run();
    end
  end
  task automatic pins(input logic m, input logic a, input int n);
    man <= m;
    aut <= a;
    repeat (n) @(posedge clk);
  endtask
  function automatic logic [7:0] rec_byte(input int i, input logic [7:0] d);
    case (i)
      3: return d[7:4] == 4'h0 ? 8'h20 : {4'h3, d[7:4]};
      4: return {4'h3, d[3:0]};
      5: return 8'h25;
      7, 8: return 8'h70;
      9: return 8'h6D;
      10: return 8'h0D;
      11: return 8'h0A;
      default: return 8'h20;
    endcase
  endfunction
  // write address, 'R', stop, then give the record time to queue
  task automatic request();
    logic ak;
    host.start();
    host.wr_byte(8'h62, ak);
    check("wr_addr_ack", ak, 1'b1);
    host.wr_byte(8'h52, ak);
    check("req_ack", ak, 1'b1);
    host.stop();
    repeat (100) @(posedge clk);
  endtask
  task automatic read_rec(input int from, input int to, input logic [7:0] d);
    logic ak;
    logic [7:0] b;
    host.start();
    host.wr_byte(8'h63, ak);
    check("rd_addr_ack", ak, 1'b1);
    for (int i = from; i <= to; i++) begin
      host.rd_byte(i == to, b);
      check("rec_byte", b, rec_byte(i, d));
    end
    host.stop();
  endtask
  ////////////////////////////////////////
  initial begin
    logic ak;
    int d0;
    int a0;
    int p0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (10) @(posedge clk);
    check("status_reset", status, 4'h2);
    for (int s = 0; s < 4; s++) begin
      bsel <= 2'(s);
      repeat (3) @(posedge clk);
      check("baud_div", div, s == 1 ? 16'h1458 : s == 2 ? 16'h0A2C : 16'h0516);
    end
    // inside, too short and too long manual holds
    foreach (dur[i]) begin
      d0 = n_done;
      a0 = n_abort;
      pins(1'b0, 1'b1, dur[i]);
      check("manual_status", status, 4'h8);
      pins(1'b1, 1'b1, 10);
      check("manual_done", 16'(n_done - d0), 16'(i == 0));
      check("manual_abort", 16'(n_abort - a0), 16'(i != 0));
    end
    p0 = n_per;
    pins(1'b1, 1'b0, 300);
    check("auto_status", status, 4'h4);
    pins(1'b1, 1'b1, 10);
    check("periodic_count", 16'(n_per - p0), 16'h1);
    pins(1'b0, 1'b0, 10);
    check("fault_status", status, 4'h3);
    pins(1'b1, 1'b1, 10);
    check("normal_status", status, 4'h2);
    host.start();
    host.wr_byte(8'h60, ak);
    check("other_addr_nack", ak, 1'b0);
    host.stop();
    request();
    read_rec(0, 6, 8'h42);
    read_rec(7, 11, 8'h42);
    // new digits must appear after the next sample
    digits <= 8'h07;
    repeat (100) @(posedge clk);
    request();
    read_rec(0, 6, 8'h07);
    complete_run();
  end
endmodule
`default_nettype wire
